/* eeprom_port_defines.svh */
// constants of the serial memory command port
`ifndef EEPROM_PORT_DEFINES_SVH
`define EEPROM_PORT_DEFINES_SVH

// ==========================================================
// clock and timing
`define SYS_CLK_PERIOD_NS 8
`define SELF_TIMED_CYCLE_TIME_MS 15
`define PROG_CYCLES ((`SELF_TIMED_CYCLE_TIME_MS * 1000000) / `SYS_CLK_PERIOD_NS)
`define TIMER_W 21
`define SHIFT_MIN_US 5
`define SHIFT_HALF_CYCLES ((`SHIFT_MIN_US * 1000 + 2 * `SYS_CLK_PERIOD_NS - 1) / (2 * `SYS_CLK_PERIOD_NS))
`define DESELECT_GAP_TIME_US 1
`define GAP_CYCLES ((`DESELECT_GAP_TIME_US * 1000 + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define STATUS_VALID_US 1
`define STATUS_CYCLES ((`STATUS_VALID_US * 1000 + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define CNT_W 10

// ==========================================================
// instruction format
`define START_MARKER_BIT 1'h1
`define ADDR_W 6
`define DATA_W 16
`define WORD_COUNT 64
`define INSTR_BITS 9
`define FRAME_BITS 25
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define OP_ERASE 2'h3
`define OP_SPECIAL 2'h0
`define SPEC_ENABLE 2'h3
`define SPEC_DISABLE 2'h0
`define SPEC_ERASE_ALL 2'h2
`define SPEC_WRITE_ALL 2'h1
`define ERASED_WORD 16'hFFFF

`endif

/* eeprom_port_pkg.sv */
// types of the serial memory command port
`include "eeprom_port_defines.svh"

package eeprom_port_pkg;

    typedef enum logic [1:0] {
        PK_ERASE,
        PK_WRITE,
        PK_ERASE_ALL,
        PK_WRITE_ALL
    } prog_kind_type;

    typedef enum logic [2:0] {
        HOP_READ,
        HOP_WRITE,
        HOP_ERASE,
        HOP_ENABLE,
        HOP_DISABLE,
        HOP_ERASE_ALL,
        HOP_WRITE_ALL
    } host_op_type;

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_GAP,
        HS_LOW,
        HS_HIGH,
        HS_POLL,
        HS_DONE
    } host_state_type;

    typedef struct packed {
        logic started;
        logic finished;
        logic [4:0] count;
        logic [23:0] shift;
        logic [15:0] out_shift;
        logic out_oe;
        logic out_bit;
    } link_type;

    typedef struct packed {
        logic prog_en;
        prog_kind_type kind;
        logic [5:0] addr;
        logic [15:0] data;
        logic toggle;
    } cmd_type;

    typedef struct packed {
        logic [1:0] sel_sync;
        logic [1:0] tog_sync;
        logic sel_prev;
        logic ack;
        logic busy;
        logic armed;
        logic [`TIMER_W-1:0] timer;
        prog_kind_type kind;
        logic [5:0] addr;
        logic [15:0] data;
    } core_type;

    typedef struct packed {
        host_state_type state;
        logic [`CNT_W-1:0] cnt;
        logic [4:0] bit_idx;
        logic [4:0] last_bit;
        logic [24:0] tx;
        logic [15:0] rx;
        logic [15:0] rdata;
        logic is_read;
        logic is_prog;
        logic poll_next;
        logic select;
        logic shift_clk;
        logic data_in;
        logic done;
        logic [1:0] do_sync;
    } host_type;

endpackage

/* eeprom_link_if.sv */
// link between host end and memory end
`timescale 1ns/1ps

interface eeprom_link_if;
    logic select_line;
    logic serial_shift_clock;
    logic serial_in_line;
    logic serial_out_data;
    logic serial_out_oe;
    logic serial_out_line;

    // undriven output line floats high through a pull-up
    assign serial_out_line = serial_out_oe ? serial_out_data : 1'b1;

    modport dev (
        input select_line,
        input serial_shift_clock,
        input serial_in_line,
        output serial_out_data,
        output serial_out_oe
    );

    modport host (
        output select_line,
        output serial_shift_clock,
        output serial_in_line,
        input serial_out_line
    );
endinterface // eeprom_link_if

/* eeprom_device.sv */
// memory end: 64 x 16 serial erasable memory with self-timed programming
`timescale 1ns/1ps
`include "eeprom_port_defines.svh"
// ==========================================================
// Operation
// - instruction is start bit, opcode, address
// - first one while selected starts instruction
// - opcode 10 read, 01 write, 11 erase
// - power-up disabled; 11xxxx enables, 00xxxx disables
// - programming needs enable; stays until disabled
// - reads ignore the enable state
// - read sends dummy zero then sixteen bits
// - read data changes on rising clock
// - output driven only for data or status
// - select fall starts erase, word to ones
// - raised select shows busy low, ready high
// - write takes sixteen bits, msb first
// - host drops select right after last bit
// - write only clears bits to zero
// - 10xxxx erases whole array
// - 01xxxx writes pattern into every word
// - clock may idle during cycle and polling
// - select low one gap between instructions
// - clock period at least five microseconds

module eeprom_device
    import eeprom_port_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    eeprom_link_if.dev link,
    output wire logic busy_o,
    output wire logic prog_enable_o
);

    localparam logic [`TIMER_W-1:0] TIMER_LOAD =
        `TIMER_W'(PROG_CYCLES - 1);

    logic [15:0] mem [`WORD_COUNT];

    link_type link_q;
    link_type next_link;
    cmd_type cmd_q;
    cmd_type next_cmd;
    core_type core_q;
    core_type next_core;

    logic link_clear;
    logic [23:0] nsh;
    logic sel_fall;
    logic commit;

    // ======================================================
    // link side: shift instruction in, data out

    // deselect parks the front end and floats the output
    assign link_clear = rst_i | ~link.select_line;
    assign nsh = {link_q.shift[22:0], link.serial_in_line};

    always_comb begin
        next_link = link_q;
        next_cmd = cmd_q;
        if (!link_q.started) begin
            if (link.serial_in_line == `START_MARKER_BIT) begin
                next_link.started = 1'b1;
                next_link.count = 5'h00;
            end
        end else if (link_q.out_oe) begin
            // dummy already out; now data, msb first
            next_link.out_bit = link_q.out_shift[15];
            next_link.out_shift = {link_q.out_shift[14:0], 1'b0};
            next_link.count = link_q.count + 5'h01;
            if (link_q.count == 5'h18) begin
                next_link.out_oe = 1'b0;
            end
        end else if (!link_q.finished) begin
            next_link.shift = nsh;
            next_link.count = link_q.count + 5'h01;
            if (link_q.count == 5'h07) begin
                case (nsh[7:6])
                    `OP_READ: begin
                        // read works in either enable state
                        next_link.out_shift = mem[nsh[5:0]];
                        next_link.out_oe = 1'b1;
                        next_link.out_bit = 1'b0;
                        next_link.finished = 1'b1;
                    end
                    `OP_ERASE: begin
                        next_link.finished = 1'b1;
                        if (cmd_q.prog_en) begin
                            next_cmd.kind = PK_ERASE;
                            next_cmd.addr = nsh[5:0];
                            next_cmd.toggle = ~cmd_q.toggle;
                        end
                    end
                    `OP_WRITE: begin
                    end
                    default: begin
                        case (nsh[5:4])
                            `SPEC_ENABLE: begin
                                next_cmd.prog_en = 1'b1;
                                next_link.finished = 1'b1;
                            end
                            `SPEC_DISABLE: begin
                                next_cmd.prog_en = 1'b0;
                                next_link.finished = 1'b1;
                            end
                            `SPEC_ERASE_ALL: begin
                                next_link.finished = 1'b1;
                                if (cmd_q.prog_en) begin
                                    next_cmd.kind = PK_ERASE_ALL;
                                    next_cmd.toggle = ~cmd_q.toggle;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                endcase
            end else if (link_q.count == 5'h17) begin
                // sixteenth data bit: write or write-all ready
                next_link.finished = 1'b1;
                if (cmd_q.prog_en) begin
                    if (nsh[23:22] == `OP_WRITE) begin
                        next_cmd.kind = PK_WRITE;
                    end else begin
                        next_cmd.kind = PK_WRITE_ALL;
                    end
                    next_cmd.addr = nsh[21:16];
                    next_cmd.data = nsh[15:0];
                    next_cmd.toggle = ~cmd_q.toggle;
                end
            end
        end
    end

    always_ff @(posedge link.serial_shift_clock or posedge link_clear) begin
        if (link_clear) begin
            link_q <= '0;
        end else begin
            link_q <= next_link;
        end
    end

    // command hold; no power-up enable
    always_ff @(posedge link.serial_shift_clock or posedge rst_i) begin
        if (rst_i) begin
            cmd_q <= '0;
        end else begin
            cmd_q <= next_cmd;
        end
    end

    // ======================================================
    // core side: self-timed programming cycle

    // command words are stable once select falls: clock is idle
    assign sel_fall = core_q.sel_prev & ~core_q.sel_sync[1];

    always_comb begin
        next_core = core_q;
        next_core.sel_sync = {core_q.sel_sync[0], link.select_line};
        next_core.tog_sync = {core_q.tog_sync[0], cmd_q.toggle};
        next_core.sel_prev = core_q.sel_sync[1];
        if (core_q.busy) begin
            next_core.timer = core_q.timer - `TIMER_W'(1);
            if (core_q.timer == '0) begin
                next_core.busy = 1'b0;
            end
        end else if (sel_fall) begin
            if (core_q.tog_sync[1] != core_q.ack) begin
                next_core.ack = core_q.tog_sync[1];
                next_core.busy = 1'b1;
                next_core.armed = 1'b1;
                next_core.timer = TIMER_LOAD;
                next_core.kind = cmd_q.kind;
                next_core.addr = cmd_q.addr;
                next_core.data = cmd_q.data;
            end else begin
                next_core.armed = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_q <= '0;
        end else begin
            core_q <= next_core;
        end
    end

    assign commit = core_q.busy && (core_q.timer == '0);

    // ======================================================
    // array: updated at the end of the cycle

    genvar gi;
    generate
        for (gi = 0; gi < `WORD_COUNT; gi = gi + 1) begin : g_word
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    mem[gi] <= `ERASED_WORD;
                end else if (commit) begin
                    case (core_q.kind)
                        PK_ERASE: begin
                            if (core_q.addr == `ADDR_W'(gi)) begin
                                mem[gi] <= `ERASED_WORD;
                            end
                        end
                        PK_WRITE: begin
                            if (core_q.addr == `ADDR_W'(gi)) begin
                                mem[gi] <= mem[gi] & core_q.data;
                            end
                        end
                        PK_ERASE_ALL: begin
                            mem[gi] <= `ERASED_WORD;
                        end
                        default: begin
                            mem[gi] <= mem[gi] & core_q.data;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ======================================================
    // output pin

    // status only while selected after a cycle was started
    assign link.serial_out_oe = link_q.out_oe |
        (core_q.sel_sync[1] & core_q.armed);
    assign link.serial_out_data = link_q.out_oe ? link_q.out_bit :
        ~core_q.busy;
    assign busy_o = core_q.busy;
    assign prog_enable_o = cmd_q.prog_en;

endmodule // eeprom_device

/* eeprom_host.sv */
// host end: drives select, clock and data in, polls status
`timescale 1ns/1ps
`include "eeprom_port_defines.svh"

module eeprom_host
    import eeprom_port_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    eeprom_link_if.host link,
    input wire logic req_i,
    input wire host_op_type op_i,
    input wire logic [5:0] addr_i,
    input wire logic [15:0] wdata_i,
    output wire logic ready_o,
    output wire logic done_o,
    output wire logic [15:0] rdata_o
);

    localparam logic [`CNT_W-1:0] HALF = `CNT_W'(`SHIFT_HALF_CYCLES - 1);
    localparam logic [`CNT_W-1:0] GAP = `CNT_W'(`GAP_CYCLES - 1);
    localparam logic [`CNT_W-1:0] STAT = `CNT_W'(`STATUS_CYCLES - 1);

    host_type q;
    host_type next_q;
    logic [1:0] op_code;
    logic [5:0] addr_field;

    // ======================================================
    // instruction encode
    always_comb begin
        op_code = `OP_SPECIAL;
        addr_field = 6'h00;
        case (op_i)
            HOP_READ: begin
                op_code = `OP_READ;
                addr_field = addr_i;
            end
            HOP_WRITE: begin
                op_code = `OP_WRITE;
                addr_field = addr_i;
            end
            HOP_ERASE: begin
                op_code = `OP_ERASE;
                addr_field = addr_i;
            end
            HOP_ENABLE: addr_field = {`SPEC_ENABLE, 4'h0};
            HOP_DISABLE: addr_field = {`SPEC_DISABLE, 4'h0};
            HOP_ERASE_ALL: addr_field = {`SPEC_ERASE_ALL, 4'h0};
            default: addr_field = {`SPEC_WRITE_ALL, 4'h0};
        endcase
    end

    // ======================================================
    // sequencer
    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        next_q.do_sync = {q.do_sync[0], link.serial_out_line};
        next_q.cnt = q.cnt - `CNT_W'(1);
        case (q.state)
            HS_IDLE: begin
                next_q.cnt = q.cnt;
                if (req_i) begin
                    next_q.tx = {`START_MARKER_BIT, op_code, addr_field,
                        wdata_i};
                    next_q.is_read = (op_i == HOP_READ);
                    next_q.is_prog = (op_i == HOP_WRITE) ||
                        (op_i == HOP_ERASE) || (op_i == HOP_ERASE_ALL) ||
                        (op_i == HOP_WRITE_ALL);
                    next_q.last_bit = (op_i == HOP_READ ||
                        op_i == HOP_WRITE || op_i == HOP_WRITE_ALL) ?
                        5'(`FRAME_BITS - 1) : 5'(`INSTR_BITS - 1);
                    next_q.poll_next = 1'b0;
                    next_q.cnt = GAP;
                    next_q.state = HS_GAP;
                end
            end
            HS_GAP: begin
                if (q.cnt == '0) begin
                    next_q.select = 1'b1;
                    if (q.poll_next) begin
                        next_q.cnt = STAT;
                        next_q.state = HS_POLL;
                    end else begin
                        next_q.bit_idx = 5'h00;
                        next_q.data_in = q.tx[24];
                        next_q.tx = {q.tx[23:0], 1'b0};
                        next_q.cnt = HALF;
                        next_q.state = HS_LOW;
                    end
                end
            end
            HS_LOW: begin
                if (q.cnt == '0) begin
                    next_q.shift_clk = 1'b1;
                    next_q.cnt = HALF;
                    next_q.state = HS_HIGH;
                end
            end
            HS_HIGH: begin
                if (q.cnt == '0) begin
                    if (q.is_read && q.bit_idx >= 5'(`INSTR_BITS)) begin
                        next_q.rx = {q.rx[14:0], q.do_sync[1]};
                    end
                    next_q.shift_clk = 1'b0;
                    next_q.bit_idx = q.bit_idx + 5'h01;
                    if (q.bit_idx == q.last_bit) begin
                        next_q.select = 1'b0;
                        next_q.data_in = 1'b0;
                        if (q.is_prog) begin
                            next_q.poll_next = 1'b1;
                            next_q.cnt = GAP;
                            next_q.state = HS_GAP;
                        end else begin
                            next_q.state = HS_DONE;
                        end
                    end else begin
                        next_q.data_in = q.tx[24];
                        next_q.tx = {q.tx[23:0], 1'b0};
                        next_q.cnt = HALF;
                        next_q.state = HS_LOW;
                    end
                end
            end
            HS_POLL: begin
                // clock stays idle while polling
                if (q.cnt == '0) begin
                    next_q.cnt = q.cnt;
                    if (q.do_sync[1]) begin
                        next_q.select = 1'b0;
                        next_q.state = HS_DONE;
                    end
                end
            end
            HS_DONE: begin
                next_q.done = 1'b1;
                next_q.rdata = q.rx;
                next_q.cnt = q.cnt;
                next_q.state = HS_IDLE;
            end
            default: begin
                next_q.state = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign link.select_line = q.select;
    assign link.serial_shift_clock = q.shift_clk;
    assign link.serial_in_line = q.data_in;
    assign ready_o = (q.state == HS_IDLE);
    assign done_o = q.done;
    assign rdata_o = q.rdata;

endmodule // eeprom_host

/* eeprom_link_chk.sv */
// link checker for the serial memory command port
`timescale 1ns/1ps

module eeprom_link_chk #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic select_line,
    input wire logic serial_shift_clock,
    input wire logic serial_in_line,
    input wire logic serial_out_data,
    input wire logic serial_out_oe,
    input wire logic serial_out_line,
    input wire logic busy_o,
    input wire logic prog_enable_o
);
    // ==========================================================
    // helper counters
    logic clk_q;
    logic clk_seen;
    logic [4:0] rd_cnt;
    logic [31:0] busy_len;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_q <= 1'b0;
            clk_seen <= 1'b0;
            rd_cnt <= 5'h00;
            busy_len <= 32'h0;
        end else begin
            clk_q <= serial_shift_clock;
            if (!select_line) begin
                clk_seen <= 1'b0;
            end else if (serial_shift_clock && !clk_q) begin
                clk_seen <= 1'b1;
            end
            if (!serial_out_oe) begin
                rd_cnt <= 5'h00;
            end else if (serial_shift_clock && !clk_q) begin
                rd_cnt <= rd_cnt + 5'h01;
            end
            if (!busy_o) begin
                busy_len <= 32'h0;
            end else begin
                busy_len <= busy_len + 32'h1;
            end
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    oe_float_a: assert property (
        !select_line [*3] |-> !serial_out_oe)
        else $error("output driven while deselected");
    read_dummy_a: assert property (
        $rose(serial_out_oe) && $rose(serial_shift_clock)
        |-> !serial_out_data) else $error("dummy bit not zero");
    read_shift_a: assert property (
        serial_out_oe && $past(serial_out_oe) && $changed(serial_out_data)
        |-> $rose(serial_shift_clock) || serial_out_data)
        else $error("read data moved without clock rise");
    read_len_a: assert property (
        $fell(select_line) && rd_cnt != 5'h00 |-> rd_cnt == 5'h11)
        else $error("read did not send dummy plus sixteen bits");
    status_valid_a: assert property (
        $rose(select_line) && busy_o
        |-> ##[1:125] (serial_out_oe && !serial_out_data))
        else $error("busy status not shown");
    status_ready_a: assert property (
        select_line && serial_out_oe && $fell(busy_o)
        |-> ##[0:8] serial_out_data) else $error("ready not shown");
    busy_start_a: assert property (
        $rose(busy_o) |-> prog_enable_o && !select_line)
        else $error("cycle started without enable or select fall");
    busy_len_a: assert property (
        $fell(busy_o) |-> busy_len >= PROG_CYCLES - 1
        && busy_len <= PROG_CYCLES + 1) else $error("cycle length wrong");
    enable_edge_a: assert property (
        $changed(prog_enable_o) |-> select_line && $rose(serial_shift_clock))
        else $error("enable changed outside an instruction");
    clock_gate_a: assert property (
        $rose(serial_shift_clock) |-> select_line)
        else $error("shift clock rose while deselected");
    start_bit_a: assert property (
        select_line && serial_shift_clock && !clk_q && !clk_seen
        |-> serial_in_line) else $error("first bit not a start bit");
    pull_up_a: assert property (
        !serial_out_oe |-> serial_out_line)
        else $error("released output line not high");
endmodule // eeprom_link_chk

/* testbench.sv */
// bench: host end drives memory end over the link
`timescale 1ns/1ps

module testbench
    import eeprom_port_pkg::*;
;
    localparam int PROG = 200;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req = 1'b0;
    host_op_type op = HOP_READ;
    logic [5:0] addr = 6'h00;
    logic [15:0] wdata = 16'h0000;
    logic ready;
    logic done;
    logic busy;
    logic prog_en;
    logic [15:0] rdata;
    logic [31:0] seed = 32'h415A;
    logic [24:0] frame = 25'h0;
    int nbits = 0;
    int last_n = 0;
    int busy_rises = 0;
    int failures = 0;
    int total_checks = 0;

    eeprom_link_if link();
    eeprom_device #(.PROG_CYCLES(PROG)) u_eeprom_device (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link.dev),
        .busy_o(busy), .prog_enable_o(prog_en));
    eeprom_host u_eeprom_host (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link.host),
        .req_i(req), .op_i(op), .addr_i(addr), .wdata_i(wdata),
        .ready_o(ready), .done_o(done), .rdata_o(rdata));
    eeprom_link_chk #(.PROG_CYCLES(PROG)) u_eeprom_link_chk (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .select_line(link.select_line),
        .serial_shift_clock(link.serial_shift_clock),
        .serial_in_line(link.serial_in_line),
        .serial_out_data(link.serial_out_data),
        .serial_out_oe(link.serial_out_oe),
        .serial_out_line(link.serial_out_line),
        .busy_o(busy), .prog_enable_o(prog_en));

    // ==========================================================
    // clock and link monitors
    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge busy) busy_rises++;

    always @(posedge link.serial_shift_clock) begin
        if (link.select_line === 1'b1) begin
            frame = {frame[23:0], link.serial_in_line};
            nbits++;
        end
    end

    always @(negedge link.select_line) begin
        if (nbits != 0) begin
            last_n = nbits;
        end
        nbits = 0;
    end

    // ==========================================================
    // helpers
    function automatic logic [15:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction

    function automatic logic [15:0] prog_word(input logic [15:0] old,
                                              input logic [15:0] d);
        return old & d;
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic run_op(input host_op_type o, input logic [5:0] a,
                          input logic [15:0] d);
        int n;
        n = 0;
        while (ready !== 1'b1) @(negedge sys_clk_i);
        req = 1'b1;
        op = o;
        addr = a;
        wdata = d;
        @(negedge sys_clk_i);
        req = 1'b0;
        while (done !== 1'b1 && n < 40000) begin
            @(negedge sys_clk_i);
            n++;
        end
        check("done", {15'h0, done}, 16'h0001);
    endtask

    // ==========================================================
    // watchdog and main sequence
    initial begin
        #(160000 * 8);
        failures++;
        print_verdict();
    end

    initial begin
        logic [5:0] a0;
        logic [15:0] d;
        logic [15:0] d2;
        a0 = 6'(rnd()) & 6'h3E;
        d2 = rnd() & 16'hFFFE;
        d = rnd() | 16'h0001;
        repeat (6) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        @(negedge sys_clk_i);
        run_op(HOP_ERASE_ALL, 6'h00, 16'h0000);
        check("cycles", 16'(busy_rises), 16'h0000);
        check("enable", {15'h0, prog_en}, 16'h0000);
        run_op(HOP_ENABLE, 6'h3F, 16'h0000);
        check("enable", {15'h0, prog_en}, 16'h0001);
        check("bits", 16'(last_n), 16'h0009);
        check("instr", 16'(frame[8:4]), 16'h0013);
        run_op(HOP_WRITE_ALL, 6'h00, d2);
        run_op(HOP_ERASE, 6'h3F, 16'h0000);
        check("cycles", 16'(busy_rises), 16'h0002);
        run_op(HOP_READ, 6'h3F, 16'h0000);
        check("rdata", rdata, 16'hFFFF);
        run_op(HOP_READ, a0, 16'h0000);
        check("rdata", rdata, prog_word(16'hFFFF, d2));
        run_op(HOP_ERASE_ALL, 6'h00, 16'h0000);
        run_op(HOP_WRITE, a0, d);
        check("bits", 16'(last_n), 16'h0019);
        check("instr", 16'(frame[24:16]), {7'h00, 3'b101, a0});
        check("wdata", frame[15:0], d);
        run_op(HOP_DISABLE, 6'h00, 16'h0000);
        check("enable", {15'h0, prog_en}, 16'h0000);
        check("cycles", 16'(busy_rises), 16'h0004);
        run_op(HOP_READ, a0, 16'h0000);
        check("rdata", rdata, prog_word(16'hFFFF, d));
        check("rdata", rdata, d);
        print_verdict();
    end
endmodule // testbench
